/* cb_if.sv */
// Carrier between the controller and one clock block
`default_nettype none
interface cb_if;
   import clk_ctrl_pkg::*;
   logic src_ext;
   logic out_en;
   logic [CB_DIV_W-1:0] div;
   logic ref_tick;
   logic ext_pin;
   logic clk_level;
   logic clk_oe;
   modport ctrl (output src_ext, out_en, div, ref_tick, ext_pin, input clk_level, clk_oe);
   modport blk (input src_ext, out_en, div, ref_tick, ext_pin, output clk_level, clk_oe);
endinterface
`default_nettype wire

/* clk_ctrl_pkg.sv */
// Shared constants for the clock control block
`default_nettype none
package clk_ctrl_pkg;
   localparam int unsigned PCLK_MHZ = 250;
   localparam int unsigned SI_OSC_MHZ = 20;
   localparam int unsigned REF_MHZ = 100;
   localparam int unsigned TIMER_TICK_NS = 10;
   localparam int unsigned TIMER_REF_DIV = TIMER_TICK_NS * REF_MHZ / 1000;
   localparam int unsigned LP_OSC_HZ = 31250;
   localparam int unsigned LP_OSC_CYCLES = PCLK_MHZ * 1000000 / LP_OSC_HZ;
   localparam int unsigned LOCK_TIME_NS = 1000;
   localparam int unsigned LOCK_CYCLES = (LOCK_TIME_NS * PCLK_MHZ + 999) / 1000;
   localparam int unsigned ACC_W = 16;
   localparam int unsigned CB_DIV_W = 8;
   // Register byte offsets
   localparam logic [7:0] PLL_CFG_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] RATIO_ADDR = 8'h08;
   localparam logic [7:0] TIMER_ADDR = 8'h0C;
   localparam logic [7:0] RTC_ADDR = 8'h10;
   localparam logic [7:0] RTC_CTRL_ADDR = 8'h14;
   localparam logic [7:0] PORT_SEL_ADDR = 8'h18;
   localparam logic [7:0] CB_CFG_ADDR = 8'h20;
   // PLL configuration fields
   localparam int unsigned OD_LSB = 0;
   localparam int unsigned F_LSB = 4;
   localparam int unsigned R_LSB = 16;
   localparam int unsigned OD_W = 3;
   localparam int unsigned F_W = 12;
   localparam int unsigned R_W = 6;
   localparam int unsigned RATIO_DEN_LSB = 16;
   // Clock block configuration fields
   localparam int unsigned CB_SRC_BIT = 0;
   localparam int unsigned CB_OE_BIT = 1;
   localparam int unsigned CB_DIV_LSB = 8;
   // Strap defaults {od, f, r}
   localparam logic [20:0] PLL_DEF_00 = {3'h1, 12'h07A, 6'h00};
   localparam logic [20:0] PLL_DEF_11 = {3'h2, 12'h077, 6'h00};
   localparam logic [20:0] PLL_DEF_10 = {3'h2, 12'h031, 6'h00};
   localparam logic [20:0] PLL_DEF_01 = {3'h2, 12'h017, 6'h00};
   typedef enum logic [1:0] {
      ST_STRAP = 2'b00,
      ST_LOCK = 2'b01,
      ST_RUN = 2'b11
   } pll_state_t;
endpackage
`default_nettype wire

/* clk_ctrl_top.sv */
// Oscillator, PLL setting and clock distribution controller
`default_nettype none
module clk_ctrl_top #(
   parameter int unsigned NUM_CB = 2,
   parameter int unsigned NUM_PORTS = 8,
   parameter int unsigned LP_PERIOD_CYCLES = clk_ctrl_pkg::LP_OSC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_clock_source_select_n,
   input wire logic freq_range_strap_bit0,
   input wire logic freq_range_strap_bit1,
   input wire logic resonator_input_pin,
   input wire logic [NUM_CB-1:0] cb_ext_clk_pin,
   output logic [NUM_CB-1:0] cb_clk_pin_o,
   output logic [NUM_CB-1:0] cb_clk_pin_oe,
   output logic [clk_ctrl_pkg::OD_W-1:0] pll_output_divider,
   output logic [clk_ctrl_pkg::F_W-1:0] pll_multiplier,
   output logic [clk_ctrl_pkg::R_W-1:0] pll_input_divider,
   output logic tile_clk_run,
   output logic switch_clk_run,
   output logic ref_clk_en,
   output logic analog_clk_en,
   output logic boot_src_silicon,
   output logic [NUM_PORTS*$clog2(NUM_CB)-1:0] port_cb_sel
);
   import clk_ctrl_pkg::*;
   localparam int unsigned SW = $clog2(NUM_CB);
   localparam int unsigned PSW = NUM_PORTS * SW;
   localparam int unsigned LCW = $clog2(LOCK_CYCLES + 1);

   pll_state_t st_r, st_nxt;
   logic [LCW-1:0] lock_cnt_r, lock_cnt_nxt;
   logic [OD_W-1:0] od_nxt;
   logic [F_W-1:0] f_nxt;
   logic [R_W-1:0] r_nxt;
   logic [1:0] range_r, range_nxt;
   logic boot_nxt, run_nxt, rtc_main_r, rtc_main_nxt;
   logic [PSW-1:0] psel_nxt;
   logic [NUM_CB-1:0] cb_src_r, cb_src_nxt, cb_oe_r, cb_oe_nxt;
   logic [CB_DIV_W-1:0] cb_div_r [NUM_CB], cb_div_nxt [NUM_CB];
   logic [31:0] rdata_nxt;
   logic ready_nxt, slverr_nxt, wr_en, relock;
   logic res_prev_r, ext_edge, osc_tick, si_tick, ref_tick, lp_tick;
   logic [31:0] timer_cnt, rtc_cnt;
   logic [12:0] ratio_num;
   logic [11:0] ratio_den;

   function automatic logic [20:0] strap_defaults(input logic [1:0] rng);
      case (rng)
         2'b00: strap_defaults = PLL_DEF_00;
         2'b11: strap_defaults = PLL_DEF_11;
         2'b10: strap_defaults = PLL_DEF_10;
         default: strap_defaults = PLL_DEF_01;
      endcase
   endfunction

   function automatic logic cb_hit(input logic [7:0] a, input int unsigned i);
      cb_hit = (a == 8'(CB_CFG_ADDR + 8'(4 * i)));
   endfunction

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = 1'b0;
      case (a)
         PLL_CFG_ADDR, STATUS_ADDR, RATIO_ADDR, TIMER_ADDR,
         RTC_ADDR, RTC_CTRL_ADDR, PORT_SEL_ADDR: known_addr = 1'b1;
         default: begin
            for (int i = 0; i < NUM_CB; i++) begin
               if (cb_hit(a, i)) begin
                  known_addr = 1'b1;
               end
            end
         end
      endcase
   endfunction

   // Ratio of tile to oscillator, exposed as numerator over denominator
   always_comb begin
      ratio_num = {1'b0, pll_multiplier} + 13'h0001;
      // Full-width product; narrow operands would wrap for large R and OD
      ratio_den = (12'({1'b0, pll_input_divider} + 7'h01)
         * 12'({1'b0, pll_output_divider} + 4'h1)) << 1;
   end

   assign wr_en = psel && penable && pwrite && pready;

   // Configuration and PLL lock sequencing
   always_comb begin
      st_nxt = st_r;
      lock_cnt_nxt = lock_cnt_r;
      od_nxt = pll_output_divider;
      f_nxt = pll_multiplier;
      r_nxt = pll_input_divider;
      range_nxt = range_r;
      boot_nxt = boot_src_silicon;
      rtc_main_nxt = rtc_main_r;
      psel_nxt = port_cb_sel;
      cb_src_nxt = cb_src_r;
      cb_oe_nxt = cb_oe_r;
      cb_div_nxt = cb_div_r;
      relock = 1'b0;
      if (wr_en) begin
         if (paddr == PLL_CFG_ADDR) begin
            // Field widths bound R, F and OD; the VCO window is software's duty
            od_nxt = pwdata[OD_LSB +: OD_W];
            f_nxt = pwdata[F_LSB +: F_W];
            r_nxt = pwdata[R_LSB +: R_W];
            relock = 1'b1;
         end
         if (paddr == RTC_CTRL_ADDR) begin
            rtc_main_nxt = pwdata[0];
         end
         if (paddr == PORT_SEL_ADDR) begin
            psel_nxt = pwdata[PSW-1:0];
         end
         for (int i = 0; i < NUM_CB; i++) begin
            if (cb_hit(paddr, i)) begin
               cb_src_nxt[i] = pwdata[CB_SRC_BIT];
               cb_oe_nxt[i] = pwdata[CB_OE_BIT];
               cb_div_nxt[i] = pwdata[CB_DIV_LSB +: CB_DIV_W];
            end
         end
      end
      case (st_r)
         ST_STRAP: begin
            // Straps taken once after reset release; board keeps them steady
            boot_nxt = boot_clock_source_select_n;
            range_nxt = {freq_range_strap_bit1, freq_range_strap_bit0};
            {od_nxt, f_nxt, r_nxt} = strap_defaults(range_nxt);
            st_nxt = ST_LOCK;
            lock_cnt_nxt = LCW'(LOCK_CYCLES - 1);
         end
         ST_LOCK: begin
            if (relock) begin
               lock_cnt_nxt = LCW'(LOCK_CYCLES - 1);
            end else if (lock_cnt_r == '0) begin
               st_nxt = ST_RUN;
            end else begin
               lock_cnt_nxt = lock_cnt_r - LCW'(1);
            end
         end
         ST_RUN: begin
            if (relock) begin
               st_nxt = ST_LOCK;
               lock_cnt_nxt = LCW'(LOCK_CYCLES - 1);
            end
         end
         default: begin
            st_nxt = ST_STRAP;
         end
      endcase
      run_nxt = (st_nxt == ST_RUN);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_STRAP;
         lock_cnt_r <= '0;
         pll_output_divider <= PLL_DEF_00[20:18];
         pll_multiplier <= PLL_DEF_00[17:6];
         pll_input_divider <= PLL_DEF_00[5:0];
         range_r <= 2'h0;
         boot_src_silicon <= 1'b0;
         rtc_main_r <= 1'b0;
         port_cb_sel <= '0;
         cb_src_r <= '0;
         cb_oe_r <= '0;
         for (int i = 0; i < NUM_CB; i++) begin
            cb_div_r[i] <= '0;
         end
         tile_clk_run <= 1'b0;
         switch_clk_run <= 1'b0;
      end else begin
         st_r <= st_nxt;
         lock_cnt_r <= lock_cnt_nxt;
         pll_output_divider <= od_nxt;
         pll_multiplier <= f_nxt;
         pll_input_divider <= r_nxt;
         range_r <= range_nxt;
         boot_src_silicon <= boot_nxt;
         rtc_main_r <= rtc_main_nxt;
         port_cb_sel <= psel_nxt;
         cb_src_r <= cb_src_nxt;
         cb_oe_r <= cb_oe_nxt;
         cb_div_r <= cb_div_nxt;
         tile_clk_run <= run_nxt;
         switch_clk_run <= run_nxt;
      end
   end

   // APB slave: no wait states, answer registered at end of setup
   always_comb begin
      ready_nxt = psel && !penable;
      slverr_nxt = 1'b0;
      rdata_nxt = '0;
      if (psel && !penable) begin
         slverr_nxt = !known_addr(paddr);
         case (paddr)
            PLL_CFG_ADDR: begin
               rdata_nxt[OD_LSB +: OD_W] = pll_output_divider;
               rdata_nxt[F_LSB +: F_W] = pll_multiplier;
               rdata_nxt[R_LSB +: R_W] = pll_input_divider;
            end
            STATUS_ADDR: rdata_nxt[4:0] = {rtc_main_r, tile_clk_run, range_r,
               boot_src_silicon};
            RATIO_ADDR: rdata_nxt = {4'h0, ratio_den, 3'h0, ratio_num};
            TIMER_ADDR: rdata_nxt = timer_cnt;
            RTC_ADDR: rdata_nxt = rtc_cnt;
            RTC_CTRL_ADDR: rdata_nxt[0] = rtc_main_r;
            PORT_SEL_ADDR: rdata_nxt[PSW-1:0] = port_cb_sel;
            default: begin
               for (int i = 0; i < NUM_CB; i++) begin
                  if (cb_hit(paddr, i)) begin
                     rdata_nxt[CB_SRC_BIT] = cb_src_r[i];
                     rdata_nxt[CB_OE_BIT] = cb_oe_r[i];
                     rdata_nxt[CB_DIV_LSB +: CB_DIV_W] = cb_div_r[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= ready_nxt;
         pslverr <= slverr_nxt;
         prdata <= rdata_nxt;
      end
   end

   // Oscillator selection; resonator edge counts as one oscillator cycle
   assign ext_edge = resonator_input_pin && !res_prev_r;
   assign osc_tick = boot_src_silicon ? si_tick : ext_edge;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_prev_r <= 1'b0;
         analog_clk_en <= 1'b0;
      end else begin
         res_prev_r <= resonator_input_pin;
         analog_clk_en <= osc_tick;
      end
   end

   rate_tick #(.STEP(SI_OSC_MHZ), .MOD(PCLK_MHZ), .CW(1)) u_si_osc (
      .clk(pclk), .rst_n(presetn), .run(1'b1), .use_ext(1'b0),
      .ext_tick(1'b0), .tick_r(si_tick), .count_r());

   // Reference only runs while the PLL is locked; timer counts 10 ns ticks
   rate_tick #(.STEP(REF_MHZ * TIMER_REF_DIV), .MOD(PCLK_MHZ), .CW(32)) u_ref (
      .clk(pclk), .rst_n(presetn), .run(tile_clk_run), .use_ext(1'b0),
      .ext_tick(1'b0), .tick_r(ref_tick), .count_r(timer_cnt));
   assign ref_clk_en = ref_tick;

   // Real-time counter survives low power on its own oscillator unless rtc_main_r selects the main oscillator
   rate_tick #(.STEP(1), .MOD(LP_PERIOD_CYCLES), .CW(32)) u_rtc (
      .clk(pclk), .rst_n(presetn), .run(1'b1), .use_ext(rtc_main_r),
      .ext_tick(osc_tick), .tick_r(lp_tick), .count_r(rtc_cnt));

   genvar g;
   generate
      for (g = 0; g < NUM_CB; g++) begin : g_cb
         cb_if cbi ();
         assign cbi.src_ext = cb_src_r[g];
         assign cbi.out_en = cb_oe_r[g];
         assign cbi.div = cb_div_r[g];
         assign cbi.ref_tick = ref_tick;
         assign cbi.ext_pin = cb_ext_clk_pin[g];
         assign cb_clk_pin_o[g] = cbi.clk_level;
         assign cb_clk_pin_oe[g] = cbi.clk_oe;
         clock_block u_cb (.clk(pclk), .rst_n(presetn), .cb(cbi.blk));
      end
   endgenerate

   boot_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_r == ST_STRAP |=> boot_src_silicon == $past(boot_clock_source_select_n))
      else $error("boot source not taken from strap");
   range_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_r == ST_STRAP |=> range_r == $past({freq_range_strap_bit1, freq_range_strap_bit0}))
      else $error("range strap not captured");
   low_defaults_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_r == ST_STRAP && !freq_range_strap_bit1 && !freq_range_strap_bit0 |=>
      pll_output_divider == 3'h1 && pll_multiplier == 12'h07A && pll_input_divider == 6'h00)
      else $error("wrong defaults for range 00");
   high_defaults_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_r == ST_STRAP && !freq_range_strap_bit1 && freq_range_strap_bit0 |=>
      pll_output_divider == 3'h2 && pll_multiplier == 12'h017 && pll_input_divider == 6'h00)
      else $error("wrong defaults for range 01");
   pll_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == PLL_CFG_ADDR |=> pll_multiplier == $past(pwdata[F_LSB +: F_W])
      && !tile_clk_run ##1 !tile_clk_run[*7])
      else $error("PLL write not applied or clocks not held");
   relock_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_r == ST_LOCK) |-> !switch_clk_run ##[1:300] tile_clk_run)
      else $error("PLL lock wait not bounded");
   ref_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      tile_clk_run && $past(tile_clk_run, 4) && !ref_tick ##1 !ref_tick && tile_clk_run
      |=> ref_tick)
      else $error("reference tick slower than 100 MHz");
   port_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_r == ST_STRAP |-> port_cb_sel == '0 && cb_src_r == '0)
      else $error("ports not on clock block 0 after reset");
   analog_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
      analog_clk_en |-> $past(boot_src_silicon ? si_tick :
      resonator_input_pin && !res_prev_r))
      else $error("analog clock not from oscillator");
endmodule
`default_nettype wire

/* clock_block.sv */
// One port clock block: external pin or divided reference
`default_nettype none
module clock_block (
   input wire logic clk,
   input wire logic rst_n,
   cb_if.blk cb
);
   import clk_ctrl_pkg::*;
   logic [CB_DIV_W-1:0] cnt_r, cnt_nxt;
   logic level_r, level_nxt, oe_r;

   always_comb begin
      cnt_nxt = cnt_r;
      level_nxt = level_r;
      if (cb.src_ext) begin
         level_nxt = cb.ext_pin;
         cnt_nxt = '0;
      end else if (cb.ref_tick) begin
         // Half period is div+1 reference ticks
         if (cnt_r >= cb.div) begin
            cnt_nxt = '0;
            level_nxt = !level_r;
         end else begin
            cnt_nxt = cnt_r + CB_DIV_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         level_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         level_r <= level_nxt;
         oe_r <= cb.out_en;
      end
   end

   assign cb.clk_level = level_r;
   assign cb.clk_oe = oe_r;

   ext_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      cb.src_ext |=> level_r == $past(cb.ext_pin))
      else $error("clock block does not follow external pin");
endmodule
`default_nettype wire

/* osc_board_model.sv */
// Board side: resonator pin and strap pins of the clock block
`default_nettype none
module osc_board_model #(
   parameter realtime HALF_NS = 10.0
) (
   input wire logic in_reset_n,
   input wire logic sel_n_req,
   input wire logic [1:0] range_req,
   output logic resonator_input_pin,
   output logic boot_clock_source_select_n,
   output logic freq_range_strap_bit0,
   output logic freq_range_strap_bit1
);
   timeunit 1ns;
   timeprecision 100ps;
   // Offset keeps oscillator edges off the bus clock edges
   initial begin
      resonator_input_pin = 1'b0;
      #1.3;
      forever #(HALF_NS) resonator_input_pin = ~resonator_input_pin;
   end
   // Straps only move while reset is held, frozen after release
   always_latch begin
      if (!in_reset_n) begin
         boot_clock_source_select_n = sel_n_req;
         freq_range_strap_bit0 = range_req[0];
         freq_range_strap_bit1 = range_req[1];
      end
   end
endmodule
`default_nettype wire

/* pll_oscillator_clock_control_bench.sv */
// Self-checking bench for the clock control block
`default_nettype none
module pll_oscillator_clock_control_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import clk_ctrl_pkg::*;
   localparam logic [11:0] EF [4] = '{12'h07A, 12'h017, 12'h031, 12'h077};
   localparam logic [2:0] EOD [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic sel_n_req, res_pin, sel_n, m0, m1, tile_run, sw_run, ref_en, an_en, boot_si;
   logic [7:0] paddr, port_sel;
   logic [31:0] pwdata, prdata, rd, t0;
   logic [1:0] range_req, ext_pin, cb_o, cb_oe;
   logic [2:0] od;
   logic [11:0] f;
   logic [5:0] r;
   int n_fail, checks, n, k;
   osc_board_model board (.in_reset_n(presetn), .sel_n_req(sel_n_req),
      .range_req(range_req), .resonator_input_pin(res_pin),
      .boot_clock_source_select_n(sel_n), .freq_range_strap_bit0(m0),
      .freq_range_strap_bit1(m1));
   clk_ctrl_top #(.LP_PERIOD_CYCLES(16)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_clock_source_select_n(sel_n), .freq_range_strap_bit0(m0),
      .freq_range_strap_bit1(m1), .resonator_input_pin(res_pin),
      .cb_ext_clk_pin(ext_pin), .cb_clk_pin_o(cb_o), .cb_clk_pin_oe(cb_oe),
      .pll_output_divider(od), .pll_multiplier(f), .pll_input_divider(r),
      .tile_clk_run(tile_run), .switch_clk_run(sw_run), .ref_clk_en(ref_en),
      .analog_clk_en(an_en), .boot_src_silicon(boot_si), .port_cb_sel(port_sel));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One full transfer; read data and error land in rd and err
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never reassigns psel in this step
      @(posedge pclk);
   endtask
   task reset_with(input logic s, input logic [1:0] m);
      presetn <= 1'b0;
      sel_n_req <= s;
      range_req <= m;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Straps are taken at the first edge; outputs are seen at the second
      repeat (2) @(posedge pclk);
   endtask
   task wait_lock();
      n = 0;
      while (tile_run !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task test_defaults();
      for (int i = 0; i < 4; i++) begin
         // Last pass boots from the resonator, which later tests rely on
         reset_with(i[0] ^ i[1], i[1:0]);
         check("od", 32'(od), 32'(EOD[i]));
         check("mult", 32'(f), 32'(EF[i]));
         check("in_div", 32'(r), 0);
         check("boot_src", 32'(boot_si), 32'(i[0] ^ i[1]));
         check("port_sel", 32'(port_sel), 0);
         apb(1'b0, STATUS_ADDR, 0);
         check("range", 32'(rd[2:1]), 32'(i[1:0]));
      end
      wait_lock();
      check("lock_time", 32'(n > 240 && n <= 252), 1);
      check("switch_run", 32'(sw_run), 1);
      $display("done defaults");
   endtask
   task test_ref_timer();
      k = 0;
      repeat (100) begin
         @(posedge pclk);
         k += int'(ref_en === 1'b1);
      end
      check("ref_ticks", k, 40);
      apb(1'b0, TIMER_ADDR, 0);
      t0 = rd;
      repeat (97) @(posedge pclk);
      apb(1'b0, TIMER_ADDR, 0);
      check("timer_step", rd - t0, 40);
      k = 0;
      repeat (200) begin
         @(posedge pclk);
         k += int'(an_en === 1'b1);
      end
      check("analog_ticks", 32'(k >= 39 && k <= 41), 1);
      $display("done ref_timer");
   endtask
   task test_pll_write();
      // 50 MHz resonator, F 39, R 1: intermediate rate 500 MHz stays in window
      apb(1'b1, PLL_CFG_ADDR, 32'h00010273);
      @(posedge pclk);
      check("relock_tile", 32'(tile_run), 0);
      check("relock_switch", 32'(sw_run), 0);
      check("new_cfg", {od, f, r}, {3'h3, 12'h027, 6'h01});
      wait_lock();
      check("relock_done", 32'(n > 240 && n <= 252), 1);
      apb(1'b0, PLL_CFG_ADDR, 0);
      check("cfg_read", rd, 32'h00010273);
      apb(1'b0, RATIO_ADDR, 0);
      check("ratio", rd, 32'h00100028);
      $display("done pll_write");
   endtask
   task test_rtc_ports();
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, RTC_CTRL_ADDR, s);
         apb(1'b0, RTC_ADDR, 0);
         t0 = rd;
         repeat (157) @(posedge pclk);
         apb(1'b0, RTC_ADDR, 0);
         k = (s == 0) ? 10 : 32;
         check("rtc_step", 32'(int'(rd - t0) >= k - 1 && int'(rd - t0) <= k + 1), 1);
      end
      apb(1'b1, CB_CFG_ADDR + 8'h04, 32'h3);
      ext_pin <= 2'b10;
      repeat (3) @(posedge pclk);
      check("cb_ext_hi", {cb_o[1], cb_oe[1]}, 2'b11);
      ext_pin <= 2'b00;
      repeat (3) @(posedge pclk);
      check("cb_ext_lo", 32'(cb_o[1]), 0);
      apb(1'b1, CB_CFG_ADDR, 32'h2);
      k = 0;
      repeat (100) begin
         @(posedge pclk);
         k += int'(cb_o[0] !== cb_o[1]);
      end
      check("cb_ref_toggle", 32'(k > 30 && k < 70 && cb_oe[0] === 1'b1), 1);
      apb(1'b1, 8'h40, 32'h1);
      check("unmapped", {err, rd}, {1'b1, 32'h0});
      apb(1'b1, PORT_SEL_ADDR, 32'hFF);
      @(posedge pclk);
      check("port_sel_w", 32'(port_sel), 32'hFF);
      $display("done rtc_ports");
   endtask
   task print_verdict();
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      n_fail++;
      print_verdict();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sel_n_req = 1'b0;
      range_req = 2'b00;
      ext_pin = 2'b00;
      test_defaults();
      test_ref_timer();
      test_pll_write();
      test_rtc_ports();
      print_verdict();
   end
endmodule
`default_nettype wire

/* rate_tick.sv */
// Fractional tick generator with an event counter
`default_nettype none
module rate_tick #(
   parameter int unsigned STEP = 1,
   parameter int unsigned MOD = 2,
   parameter int unsigned CW = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic use_ext,
   input wire logic ext_tick,
   output logic tick_r,
   output logic [CW-1:0] count_r
);
   import clk_ctrl_pkg::*;
   logic [ACC_W-1:0] acc_r, acc_nxt;
   logic [ACC_W:0] acc_sum;
   logic int_tick, sel, tick_nxt;
   logic [CW-1:0] count_nxt;

   // Phase accumulator gives exact average rate without a faster clock
   always_comb begin
      acc_sum = {1'b0, acc_r} + (ACC_W+1)'(STEP);
      int_tick = run && (acc_sum >= (ACC_W+1)'(MOD));
      acc_nxt = acc_r;
      if (int_tick) begin
         acc_nxt = ACC_W'(acc_sum - (ACC_W+1)'(MOD));
      end else if (run) begin
         acc_nxt = acc_sum[ACC_W-1:0];
      end
      sel = use_ext ? (run && ext_tick) : int_tick;
      tick_nxt = sel;
      count_nxt = count_r + CW'(sel);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= '0;
         tick_r <= 1'b0;
         count_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         tick_r <= tick_nxt;
         count_r <= count_nxt;
      end
   end

   count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      sel |=> (count_r == $past(count_r) + CW'(1)) && tick_r)
      else $error("counter did not advance on tick");
   count_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sel |=> $stable(count_r) && !tick_r)
      else $error("counter moved without tick");
endmodule
`default_nettype wire
